// >>> rtl/safety_status_led_diagnostics.sv
// Status lamps, start handling and latched error safe state of the safety relay.
`timescale 1ns/1ps
`default_nettype none
`include "status_lamp_regs.svh"

// Summary of operation
// - Outside the safe state, the output-state lamp is lit exactly while the safety outputs are on.
// - A start lamp is dark when start is unmet, lit when met and flashes while waiting.
// - Basic wiring reports on the first start lamp, monitored wiring on the second.
// - Any error turns the outputs off, enters the safe state and lights the error lamp.
// - The safe state holds regardless of inputs until a power-on reset.
// - A general error flashes output-state and both start lamps in phase.
// - A supply fault flashes the supply lamp.
// - A start input cross circuit flashes only the first start lamp.
// - Both start wirings present is an error and flashes both start lamps in phase.
// - A safety output fault flashes the output-state lamp.
// - Monitored start enables outputs only on the fall of a pulse held at least 80 ms.
module safety_status_led_diagnostics (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic supply_ok,
   input wire logic wired_basic_start,
   input wire logic wired_monitored_start,
   input wire logic start_input,
   input wire logic start_waiting,
   input wire logic release_request,
   input wire status_lamp_pkg::fault_flags_type fault_flags,
   output logic outputs_on,
   output logic safe_state,
   output status_lamp_pkg::lamp_set_type lamps
);
   import status_lamp_pkg::*;

   // -----------------------------------------------------------------
   // Flash toggle
   // -----------------------------------------------------------------
   logic [`COUNT_WIDTH-1:0] flash_count_reg, flash_count_next;
   logic flash_reg, flash_next;

   always_comb begin
      flash_count_next = flash_count_reg + `COUNT_WIDTH'(1);
      flash_next = flash_reg;
      if (flash_count_reg == `COUNT_WIDTH'(`FLASH_HALF_CYCLES - 1)) begin
         flash_count_next = '0;
         flash_next = ~flash_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         flash_count_reg <= '0;
         flash_reg <= 1'b0;
      end else begin
         flash_count_reg <= flash_count_next;
         flash_reg <= flash_next;
      end
   end

   // -----------------------------------------------------------------
   // Fault classification and latched safe state
   // -----------------------------------------------------------------
   start_mode_type mode;
   fault_class_type fault_now;
   fault_class_type fault_reg, fault_next;

   always_comb begin
      mode = start_mode_type'({wired_monitored_start, wired_basic_start});
      if (fault_flags.supply_fault || !supply_ok) begin
         fault_now = FAULT_SUPPLY;
      end else if (mode == START_MODE_BOTH) begin
         fault_now = FAULT_WIRING;
      end else if (fault_flags.start_cross_fault) begin
         fault_now = FAULT_CROSS;
      end else if (fault_flags.output_fault) begin
         fault_now = FAULT_OUTPUT;
      end else if (fault_flags.general_fault) begin
         fault_now = FAULT_GENERAL;
      end else begin
         fault_now = FAULT_NONE;
      end
      fault_next = fault_reg;
      if (fault_reg == FAULT_NONE) begin
         fault_next = fault_now;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         fault_reg <= FAULT_NONE;
      end else begin
         fault_reg <= fault_next;
      end
   end

   // -----------------------------------------------------------------
   // Start handling and output enable
   // -----------------------------------------------------------------
   logic [`COUNT_WIDTH-1:0] pulse_count_reg, pulse_count_next;
   logic start_prev_reg, start_prev_next;
   logic out_reg, out_next;
   logic pulse_long;

   always_comb begin
      pulse_long = (pulse_count_reg >= `COUNT_WIDTH'(`START_PULSE_MIN_CYCLES));
      start_prev_next = start_input;
      pulse_count_next = '0;
      if (start_input) begin
         pulse_count_next = pulse_long ? pulse_count_reg
                                       : pulse_count_reg + `COUNT_WIDTH'(1);
      end
      out_next = out_reg;
      if (release_request) begin
         out_next = 1'b0;
      end else if (mode == START_MODE_MONITORED) begin
         if (start_prev_reg && !start_input && pulse_long) begin
            out_next = 1'b1;
         end
      end else if (mode == START_MODE_BASIC && start_input) begin
         out_next = 1'b1;
      end
      if (fault_reg != FAULT_NONE || fault_now != FAULT_NONE) begin
         out_next = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pulse_count_reg <= '0;
         start_prev_reg <= 1'b0;
         out_reg <= 1'b0;
      end else begin
         pulse_count_reg <= pulse_count_next;
         start_prev_reg <= start_prev_next;
         out_reg <= out_next;
      end
   end

   // -----------------------------------------------------------------
   // Lamp patterns
   // -----------------------------------------------------------------
   lamp_set_type lamps_next;
   logic start_show;

   always_comb begin
      if (out_next) begin
         start_show = 1'b1;
      end else if (start_waiting) begin
         start_show = flash_next;
      end else begin
         start_show = 1'b0;
      end
      lamps_next = '0;
      lamps_next.supply_lamp = supply_ok;
      lamps_next.output_state_lamp = out_next;
      lamps_next.start_lamp_basic_mode = (mode == START_MODE_BASIC) && start_show;
      lamps_next.start_lamp_monitored_mode = (mode == START_MODE_MONITORED) && start_show;
      case (fault_next)
         FAULT_NONE: begin
         end
         FAULT_GENERAL: begin
            lamps_next = '0;
            lamps_next.supply_lamp = 1'b1;
            lamps_next.error_lamp = 1'b1;
            lamps_next.output_state_lamp = flash_next;
            lamps_next.start_lamp_basic_mode = flash_next;
            lamps_next.start_lamp_monitored_mode = flash_next;
         end
         FAULT_SUPPLY: begin
            lamps_next = '0;
            lamps_next.error_lamp = 1'b1;
            lamps_next.supply_lamp = flash_next;
         end
         FAULT_CROSS: begin
            lamps_next = '0;
            lamps_next.supply_lamp = 1'b1;
            lamps_next.error_lamp = 1'b1;
            lamps_next.start_lamp_basic_mode = flash_next;
         end
         FAULT_WIRING: begin
            lamps_next = '0;
            lamps_next.supply_lamp = 1'b1;
            lamps_next.error_lamp = 1'b1;
            lamps_next.start_lamp_basic_mode = flash_next;
            lamps_next.start_lamp_monitored_mode = flash_next;
         end
         FAULT_OUTPUT: begin
            lamps_next = '0;
            lamps_next.supply_lamp = 1'b1;
            lamps_next.error_lamp = 1'b1;
            lamps_next.output_state_lamp = flash_next;
         end
         default: begin
            lamps_next = '0;
            lamps_next.error_lamp = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         lamps <= '0;
         outputs_on <= 1'b0;
         safe_state <= 1'b0;
      end else begin
         lamps <= lamps_next;
         outputs_on <= out_next;
         safe_state <= (fault_next != FAULT_NONE);
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   // Lamps and outputs are registered from the same next values, so a check that
   // relates them to the wiring or the start inputs looks at those of the cycle before.
   AST_STATE_LAMP: assert property (lamps.output_state_lamp == outputs_on || safe_state)
      else $error("output-state lamp differs from outputs");
   AST_RELEASE_OFF: assert property (release_request
      |=> safe_state || !lamps.output_state_lamp)
      else $error("output-state lamp lit after release");
   AST_BASIC_RUN: assert property (start_input && wired_basic_start
      && !wired_monitored_start && !release_request |=> outputs_on || safe_state)
      else $error("basic start did not switch the outputs on");
   AST_BASIC_DARK: assert property (!safe_state && $past(wired_monitored_start)
      |-> !lamps.start_lamp_basic_mode)
      else $error("basic start lamp lit in monitored wiring");
   AST_MON_DARK: assert property (!safe_state && $past(wired_basic_start)
      |-> !lamps.start_lamp_monitored_mode)
      else $error("monitored start lamp lit in basic wiring");
   AST_START_ON: assert property (!safe_state && outputs_on
      && $past(wired_basic_start) && !$past(wired_monitored_start)
      |-> lamps.start_lamp_basic_mode)
      else $error("start lamp dark while condition met");
   AST_START_DARK: assert property (!safe_state && !outputs_on && !$past(start_waiting)
      |-> !lamps.start_lamp_basic_mode && !lamps.start_lamp_monitored_mode)
      else $error("start lamp lit while condition unmet");
   AST_WAIT_FLASH: assert property (!safe_state && !outputs_on && $past(start_waiting)
      && $past(wired_basic_start) && !$past(wired_monitored_start)
      |-> lamps.start_lamp_basic_mode == flash_reg)
      else $error("start lamp not flashing while waiting");

   AST_FAULT_OFF: assert property (fault_flags.output_fault
      |=> !outputs_on && safe_state)
      else $error("outputs stay on after fault");
   AST_ANY_FAULT: assert property (fault_flags != '0 || !supply_ok
      || (wired_basic_start && wired_monitored_start) |=> !outputs_on && safe_state)
      else $error("detected error did not enter the safe state");
   AST_GENERAL_CAUSE: assert property (fault_flags.general_fault |=> safe_state)
      else $error("general error not latched");
   AST_SUPPLY_CAUSE: assert property (!supply_ok |=> safe_state)
      else $error("supply fault not latched");
   AST_CROSS_CAUSE: assert property (fault_flags.start_cross_fault |=> safe_state)
      else $error("cross circuit not latched");
   AST_WIRING_CAUSE: assert property (wired_basic_start && wired_monitored_start
      |=> safe_state)
      else $error("double start wiring not latched");
   AST_SAFE_HOLD: assert property (safe_state |=> safe_state && !outputs_on)
      else $error("safe state left without reset");
   AST_ERR_LAMP: assert property (safe_state |-> lamps.error_lamp)
      else $error("error lamp dark in safe state");
   AST_ERR_DARK: assert property (!safe_state |-> !lamps.error_lamp)
      else $error("error lamp lit outside the safe state");
   AST_SUPPLY_LIT: assert property (!safe_state && !$past(sys_rst)
      |-> lamps.supply_lamp)
      else $error("supply lamp dark without a supply fault");
   AST_GENERAL_SYNC: assert property (fault_reg == FAULT_GENERAL |=>
      lamps.output_state_lamp == flash_reg && lamps.start_lamp_basic_mode == flash_reg
      && lamps.start_lamp_monitored_mode == flash_reg)
      else $error("general error lamps out of phase");
   AST_WIRING_SYNC: assert property (fault_reg == FAULT_WIRING |=>
      lamps.start_lamp_basic_mode == flash_reg && lamps.start_lamp_monitored_mode == flash_reg
      && !lamps.output_state_lamp)
      else $error("wiring error lamps out of phase");
   AST_CROSS_ONLY: assert property (fault_reg == FAULT_CROSS |=>
      !lamps.start_lamp_monitored_mode && !lamps.output_state_lamp
      && lamps.start_lamp_basic_mode == flash_reg)
      else $error("cross circuit flashes wrong lamp");
   AST_SUPPLY_FLASH: assert property (fault_reg == FAULT_SUPPLY |=>
      lamps.supply_lamp == flash_reg)
      else $error("supply lamp not flashing");
   AST_OUT_FLASH: assert property (fault_reg == FAULT_OUTPUT |=>
      lamps.output_state_lamp == flash_reg)
      else $error("output lamp not flashing");
   AST_MON_EDGE: assert property ($rose(outputs_on) && $past(wired_monitored_start)
      && !$past(wired_basic_start) |-> $past(start_prev_reg) && !$past(start_input))
      else $error("monitored start without falling edge");
   AST_MON_LONG: assert property ($rose(outputs_on) && $past(wired_monitored_start)
      && !$past(wired_basic_start) |-> $past(pulse_long))
      else $error("monitored start after a short pulse");
   AST_FLASH_STEP: assert property ($changed(flash_reg) |-> flash_count_reg == '0)
      else $error("flash toggle off its period");
   AST_FLASH_RANGE: assert property (flash_count_reg
      < `COUNT_WIDTH'(`FLASH_HALF_CYCLES))
      else $error("flash counter past its half period");

   // -----------------------------------------------------------------
   // Coverage
   // -----------------------------------------------------------------
   COV_FAULT: cover property ($rose(safe_state));
   COV_MON_START: cover property ($rose(outputs_on) && wired_monitored_start);
   COV_BASIC_START: cover property ($rose(outputs_on) && wired_basic_start);
   COV_FLASH: cover property ($rose(flash_reg));
   COV_RELEASE: cover property ($fell(outputs_on) && !safe_state);

endmodule
`default_nettype wire

// >>> include/status_lamp_regs.svh
// Timing constants for the status lamp block.
`ifndef STATUS_LAMP_REGS_SVH
`define STATUS_LAMP_REGS_SVH

`define CLOCK_HZ 40000000
`define FLASH_HALF_MS 250
`define FLASH_HALF_CYCLES ((`CLOCK_HZ / 1000) * `FLASH_HALF_MS)
`define START_PULSE_MIN_MS 80
`define START_PULSE_MIN_CYCLES ((`CLOCK_HZ / 1000) * `START_PULSE_MIN_MS)
`define COUNT_WIDTH 24

`endif

// >>> include/status_lamp_pkg.sv
// Types shared by the status lamp block.
package status_lamp_pkg;

   typedef enum logic [1:0] {
      START_MODE_NONE,
      START_MODE_BASIC,
      START_MODE_MONITORED,
      START_MODE_BOTH
   } start_mode_type;

   typedef struct packed {
      logic general_fault;
      logic supply_fault;
      logic start_cross_fault;
      logic output_fault;
   } fault_flags_type;

   typedef struct packed {
      logic supply_lamp;
      logic output_state_lamp;
      logic start_lamp_basic_mode;
      logic start_lamp_monitored_mode;
      logic error_lamp;
   } lamp_set_type;

   typedef enum logic [2:0] {
      FAULT_NONE,
      FAULT_GENERAL,
      FAULT_SUPPLY,
      FAULT_CROSS,
      FAULT_WIRING,
      FAULT_OUTPUT
   } fault_class_type;

endpackage

// >>> verification/safety_status_led_diagnostics_tb.sv
// Self-checking bench for the status lamps, start handling and latched safe state.
`timescale 1ns/1ps
`default_nettype none
module safety_status_led_diagnostics_tb;
   import status_lamp_pkg::*;

   typedef struct {
      string name;
      logic [6:0] value;
      logic [6:0] care;
      logic [4:0] sync;
   } note_type;

   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic supply_ok = 1'b1;
   logic wired_basic_start = 1'b1;
   logic wired_monitored_start = 1'b0;
   logic start_input = 1'b0;
   logic start_waiting = 1'b0;
   logic release_request = 1'b0;
   fault_flags_type fault_flags = '0;
   logic outputs_on;
   logic safe_state;
   lamp_set_type lamps;
   int error_cnt = 0;
   int checks_done = 0;
   logic [31:0] rnd = 32'h0000_1740;
   note_type notes[$];
   event check_ev;
   logic [6:0] fault_value [5] = '{7'h31, 7'h21, 7'h31, 7'h31, 7'h31};
   logic [4:0] fault_flash [5] = '{5'h0e, 5'h10, 5'h04, 5'h06, 5'h08};

   safety_status_led_diagnostics safety_status_led_diagnostics_inst (
      .clock(clock),
      .sys_rst(sys_rst),
      .supply_ok(supply_ok),
      .wired_basic_start(wired_basic_start),
      .wired_monitored_start(wired_monitored_start),
      .start_input(start_input),
      .start_waiting(start_waiting),
      .release_request(release_request),
      .fault_flags(fault_flags),
      .outputs_on(outputs_on),
      .safe_state(safe_state),
      .lamps(lamps)
   );

   always #12.5 clock = ~clock;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic wrap_up();
      $display("Checks done %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Power-on reset with the normal basic wiring; ends just after a falling edge.
   task automatic do_reset();
      @(negedge clock);
      sys_rst = 1'b1;
      supply_ok = 1'b1;
      wired_basic_start = 1'b1;
      wired_monitored_start = 1'b0;
      start_input = 1'b0;
      start_waiting = 1'b0;
      release_request = 1'b0;
      fault_flags = '0;
      repeat (6) @(negedge clock);
      sys_rst = 1'b0;
   endtask

   // Lets the registered outputs settle, then files the note for the watcher.
   task automatic expect_state(input string name, input logic [6:0] value,
                               input logic [6:0] care, input logic [4:0] sync);
      note_type n;
      repeat (2) @(posedge clock);
      @(negedge clock);
      n = '{name, value, care, sync};
      notes.push_back(n);
      ->check_ev;
   endtask

   // ----------------------------------------------------------------------
   // Watcher
   // ----------------------------------------------------------------------
   always @(check_ev) begin
      note_type n;
      logic [6:0] seen;
      logic [4:0] grp;
      n = notes.pop_front();
      seen = {outputs_on, safe_state, lamps};
      grp = lamps & n.sync;
      checks_done++;
      if ((seen & n.care) !== (n.value & n.care)) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", n.name, n.value & n.care, seen);
      end
      checks_done++;
      if (grp !== 5'h00 && grp !== n.sync) begin
         error_cnt++;
         $display("BAD %s_phase expected %h seen %h", n.name, n.sync, grp);
      end
   end

   initial begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      wrap_up();
   end

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   initial begin
      int len;
      logic [6:0] fcare;
      do_reset();
      expect_state("idle", 7'h10, 7'h7f, 5'h00);
      start_waiting = 1'b1;
      expect_state("waiting", 7'h10, 7'h7b, 5'h00);
      start_waiting = 1'b0;
      start_input = 1'b1;
      expect_state("basic_run", 7'h5c, 7'h7f, 5'h00);
      start_input = 1'b0;
      release_request = 1'b1;
      expect_state("released", 7'h10, 7'h7f, 5'h00);
      release_request = 1'b0;
      wired_basic_start = 1'b0;
      wired_monitored_start = 1'b1;
      rnd = lfsr_next(rnd);
      len = 1 + int'(rnd[9:0]);
      start_input = 1'b1;
      repeat (len) @(negedge clock);
      start_input = 1'b0;
      expect_state("short_pulse", 7'h10, 7'h7f, 5'h00);
      for (int k = 0; k < 5; k++) begin
         do_reset();
         start_input = 1'b1;
         expect_state("pre_fault", 7'h5c, 7'h7f, 5'h00);
         case (k)
            0: fault_flags.general_fault = 1'b1;
            1: supply_ok = 1'b0;
            2: fault_flags.start_cross_fault = 1'b1;
            3: wired_monitored_start = 1'b1;
            default: fault_flags.output_fault = 1'b1;
         endcase
         fcare = {2'b11, ~fault_flash[k]};
         expect_state("fault", fault_value[k], fcare, fault_flash[k]);
         supply_ok = 1'b1;
         fault_flags = '0;
         wired_monitored_start = 1'b0;
         for (int i = 0; i < 20; i++) begin
            @(negedge clock);
            rnd = lfsr_next(rnd);
            start_input = rnd[0];
            start_waiting = rnd[1];
            release_request = rnd[2];
         end
         expect_state("held", fault_value[k], fcare, fault_flash[k]);
      end
      do_reset();
      expect_state("power_cycle", 7'h10, 7'h7f, 5'h00);
      wrap_up();
   end
endmodule
`default_nettype wire
